// ==== pmcd_pkg.sv ====
/*
 * pmcd_pkg: constants, command codes and types for the command decoder.
 * Assumes mclk at 250 MHz; link pins (scl/sda/straps) come from outside.
 */
// Functional notes
// - Host honours clock stretching; device stretches SCL while busy.
// - No status byte ever carries a busy flag.
// - Only implemented command codes decode as valid.
// - Status reads 78h..7Eh and 80h served; CLEAR_FAULTS 03h clears latches.
// - Telemetry reads served; 8Eh and 90h rejected.
// - Vendor configuration and control range commands accepted.
// - Act as a compliant SMBus/PMBus slave on transport and framing.
// - Bus address is 25 times high strap index plus low index.
// - Alert output asserts while any fault or warning is latched.
// - Never answer at address 4Bh.
`default_nettype none
package pmcd_pkg;
    localparam logic [6:0] ADDR_PROD      = 7'h4b;
    localparam int         STRAP_MULT     = 25;
    localparam logic [7:0] CMD_CLEAR      = 8'h03;
    localparam logic [7:0] CMD_STORE_DEF  = 8'h11;
    localparam logic [7:0] CMD_STORE_USR  = 8'h15;
    localparam logic [7:0] CMD_STAT_BYTE  = 8'h78;
    localparam logic [7:0] CMD_STAT_CML   = 8'h7e;
    localparam logic [7:0] CMD_VENDOR_ST  = 8'h80;
    localparam logic [7:0] CMD_GEN_CFG    = 8'hd0;
    localparam logic [7:0] CMD_MISC_CFG   = 8'he9;
    localparam logic [7:0] CMD_TAP_CALC   = 8'hf2;
    localparam int         CML_INVALID    = 7;
    localparam int         STAT_CML_BIT   = 1;
    localparam logic [7:0] STATUS_RESET   = 8'h00;
    localparam int         CLK_MHZ        = 250;
    localparam int         STRETCH_NS     = 200;
    localparam int         STRETCH_CYC    = (STRETCH_NS * CLK_MHZ + 999) / 1000;
    localparam int         STORE_MS       = 20;
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_CMD, ST_WDATA, ST_RDATA, ST_ACK, ST_RACK
    } pmcd_state_t;
endpackage : pmcd_pkg
`default_nettype wire

// ==== pmcd_cmd_table.sv ====
/*
 * pmcd_cmd_table: combinational lookup of implemented command codes.
 * Assumes the code is stable in the cycle it is looked up.
 */
`timescale 1ns/1ns
`default_nettype none
module pmcd_cmd_table (
    input  wire logic [7:0] code,
    output logic            valid,
    output logic            read_only
);
    logic [255:0] impl;
    always_comb begin
        impl = '0;
        // control, output and calibration
        impl[8'h01] = 1'b1; impl[8'h02] = 1'b1; impl[8'h03] = 1'b1;
        for (int i = 8'h20; i <= 8'h28; i++) impl[i] = 1'b1;
        impl[8'h32] = 1'b1; impl[8'h33] = 1'b1; impl[8'h37] = 1'b1;
        impl[8'h38] = 1'b1; impl[8'h39] = 1'b1;
        impl[8'h11] = 1'b1; impl[8'h12] = 1'b1; impl[8'h15] = 1'b1; impl[8'h16] = 1'b1;
        // limits and responses; 42h,43h,4Ah,47h,4Ch,5Fh excluded
        impl[8'h40] = 1'b1; impl[8'h41] = 1'b1; impl[8'h44] = 1'b1; impl[8'h45] = 1'b1;
        impl[8'h46] = 1'b1; impl[8'h4b] = 1'b1; impl[8'h4f] = 1'b1;
        for (int i = 8'h50; i <= 8'h5a; i++) impl[i] = 1'b1;
        impl[8'h5e] = 1'b1;
        impl[8'h60] = 1'b1; impl[8'h61] = 1'b1; impl[8'h64] = 1'b1; impl[8'h65] = 1'b1;
        for (int i = 8'h78; i <= 8'h7e; i++) impl[i] = 1'b1;
        impl[8'h80] = 1'b1;
        impl[8'h88] = 1'b1; impl[8'h8b] = 1'b1; impl[8'h8c] = 1'b1;
        impl[8'h8d] = 1'b1; impl[8'h94] = 1'b1; impl[8'h95] = 1'b1;
        for (int i = 8'h98; i <= 8'h9e; i++) impl[i] = 1'b1;
        // vendor range
        impl[8'hb0] = 1'b1; impl[8'hbe] = 1'b1; impl[8'hbf] = 1'b1;
        for (int i = 8'hd0; i <= 8'hd8; i++) impl[i] = 1'b1;
        impl[8'hdc] = 1'b1; impl[8'hdd] = 1'b1; impl[8'hde] = 1'b1;
        for (int i = 8'he0; i <= 8'he9; i++) impl[i] = 1'b1;
        impl[8'he3] = 1'b0; // unassigned gap inside the range
        impl[8'hea] = 1'b1; impl[8'hf0] = 1'b1; impl[8'hf2] = 1'b1; impl[8'hf3] = 1'b1;
        for (int i = 8'hfa; i <= 8'hfd; i++) impl[i] = 1'b1;
    end
    assign valid     = impl[code];
    assign read_only = (code == 8'h20) || ((code >= 8'h78) && (code <= 8'h9e));
endmodule : pmcd_cmd_table
`default_nettype wire

// ==== pmcd_top.sv ====
/*
 * pmcd_top: SMBus slave framing plus command decode for a regulator.
 * Assumes scl/sda and straps are asynchronous pins; mclk far faster than scl.
 * Fault sources are levels from the regulator core on mclk.
 */
`timescale 1ns/1ns
`default_nettype none
module pmcd_top #(
    parameter int STRAP_W = 5
) (
    input  wire logic               mclk,
    input  wire logic               reset,
    input  wire logic               scl_in,
    output logic                    scl_oe_n,
    input  wire logic               sda_in,
    output logic                    sda_oe_n,
    input  wire logic [STRAP_W-1:0] addr_strap_low,
    input  wire logic [2:0]         addr_strap_high,
    input  wire logic [7:0]         fault_in,
    input  wire logic               core_busy,
    output logic                    fault_alert_oe_n,
    output logic                    fault_alert_out,
    output logic [7:0]              cmd_code,
    output logic                    cmd_strobe,
    output logic [7:0]              wr_data,
    output logic                    wr_strobe,
    input  wire logic [7:0]         rd_data,
    output logic                    clear_faults,
    output logic                    nvm_store,
    output logic [7:0]              cml_status
);
    logic [1:0] scl_s_q, sda_s_q;
    logic       scl_q, sda_q;
    logic [6:0] addr_q;
    logic       addr_ok_q, rw_q;
    logic [7:0] sh_q, tx_q, fault_q;
    logic [3:0] bit_q;
    logic       sda_drv_q, stretch_q, cmd_seen_q;
    logic [7:0] str_cnt_q;
    logic       is_valid;
    logic [STRAP_W-1:0] lo_s1_q, lo_s2_q;
    logic [2:0]         hi_s1_q, hi_s2_q;
    pmcd_pkg::pmcd_state_t st_q;

    // written read-only codes are not refused, so the table's flag goes unused
    pmcd_cmd_table u_tab (
        .code      (sh_q),
        .valid     (is_valid),
        .read_only ()
    );

    // pins pass two flops before any logic
    always_ff @(posedge mclk) begin
        scl_s_q <= {scl_s_q[0], scl_in};
        sda_s_q <= {sda_s_q[0], sda_in};
        scl_q   <= scl_s_q[1];
        sda_q   <= sda_s_q[1];
        lo_s1_q <= addr_strap_low;
        lo_s2_q <= lo_s1_q;
        hi_s1_q <= addr_strap_high;
        hi_s2_q <= hi_s1_q;
    end

    wire scl = scl_s_q[1];
    wire sda = sda_s_q[1];
    wire scl_rise = scl & ~scl_q;
    wire scl_fall = ~scl & scl_q;
    wire start_c  = scl & scl_q & sda_q & ~sda;
    wire stop_c   = scl & scl_q & ~sda_q & sda;
    wire [7:0] sh_next = {sh_q[6:0], sda};

    // straps are quasi-static pins, yet still pass two flops before use
    wire [9:0] addr_calc = 10'(hi_s2_q) * 10'(pmcd_pkg::STRAP_MULT)
                         + 10'(lo_s2_q);
    always_ff @(posedge mclk) begin
        if (reset) begin
            addr_q    <= 7'h00;
            addr_ok_q <= 1'b0;
        end else begin
            addr_q    <= addr_calc[6:0];
            addr_ok_q <= (addr_calc < 10'h080) && (addr_calc[6:0] != pmcd_pkg::ADDR_PROD);
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            st_q <= pmcd_pkg::ST_IDLE; bit_q <= 4'h0; sh_q <= 8'h00; rw_q <= 1'b0;
            sda_drv_q <= 1'b0; cmd_seen_q <= 1'b0; tx_q <= 8'h00; wr_data <= 8'h00;
            cmd_strobe <= 1'b0; wr_strobe <= 1'b0; clear_faults <= 1'b0; nvm_store <= 1'b0;
            cml_status <= pmcd_pkg::STATUS_RESET; cmd_code <= 8'h00;
        end else begin
            cmd_strobe <= 1'b0; wr_strobe <= 1'b0; clear_faults <= 1'b0; nvm_store <= 1'b0;
            if (start_c) begin
                st_q <= pmcd_pkg::ST_ADDR; bit_q <= 4'h0; sda_drv_q <= 1'b0;
                cmd_seen_q <= 1'b0;
            end else if (stop_c) begin
                st_q <= pmcd_pkg::ST_IDLE; sda_drv_q <= 1'b0;
            end else begin
                case (st_q)
                pmcd_pkg::ST_IDLE: ;
                pmcd_pkg::ST_ADDR, pmcd_pkg::ST_CMD, pmcd_pkg::ST_WDATA: begin
                    if (scl_rise) begin
                        sh_q <= sh_next; bit_q <= bit_q + 4'h1;
                    end
                    if (scl_fall && bit_q == 4'h8) begin
                        bit_q <= 4'h0;
                        if (st_q == pmcd_pkg::ST_ADDR) begin
                            if (addr_ok_q && sh_q[7:1] == addr_q) begin
                                rw_q <= sh_q[0]; sda_drv_q <= 1'b1;
                                st_q <= sh_q[0] ? pmcd_pkg::ST_RACK : pmcd_pkg::ST_ACK;
                                if (sh_q[0]) tx_q <= rd_data;
                            end else st_q <= pmcd_pkg::ST_IDLE;
                        end else if (st_q == pmcd_pkg::ST_CMD) begin
                            sda_drv_q <= 1'b1; st_q <= pmcd_pkg::ST_ACK;
                            cmd_seen_q <= 1'b1; cmd_code <= sh_q;
                            if (is_valid) begin
                                cmd_strobe   <= 1'b1;
                                clear_faults <= (sh_q == pmcd_pkg::CMD_CLEAR);
                                nvm_store    <= (sh_q == pmcd_pkg::CMD_STORE_DEF) ||
                                                (sh_q == pmcd_pkg::CMD_STORE_USR);
                            end else begin
                                cml_status[pmcd_pkg::CML_INVALID] <= 1'b1;
                                sda_drv_q <= 1'b0;
                                st_q <= pmcd_pkg::ST_IDLE;
                            end
                        end else begin
                            wr_data <= sh_q; wr_strobe <= 1'b1;
                            sda_drv_q <= 1'b1; st_q <= pmcd_pkg::ST_ACK;
                        end
                    end
                end
                pmcd_pkg::ST_ACK: if (scl_fall) begin
                    sda_drv_q <= 1'b0;
                    // per-frame flag: the last command must not leak into the next frame
                    st_q <= cmd_seen_q ? pmcd_pkg::ST_WDATA : pmcd_pkg::ST_CMD;
                    if (rw_q) begin
                        st_q <= pmcd_pkg::ST_RDATA; sda_drv_q <= ~tx_q[7];
                    end
                end
                pmcd_pkg::ST_RACK, pmcd_pkg::ST_RDATA: begin
                    if (st_q == pmcd_pkg::ST_RACK && scl_fall) begin
                        st_q <= pmcd_pkg::ST_RDATA; sda_drv_q <= ~tx_q[7]; bit_q <= 4'h0;
                    end else if (st_q == pmcd_pkg::ST_RDATA && scl_fall) begin
                        bit_q <= bit_q + 4'h1;
                        if (bit_q == 4'h7) sda_drv_q <= 1'b0;
                        else sda_drv_q <= ~tx_q[3'd6 - bit_q[2:0]];
                        if (bit_q == 4'h8) begin
                            // host nack ends the read; ack fetches next byte
                            if (sda_q) begin
                                // release so the host can make its stop
                                st_q <= pmcd_pkg::ST_IDLE; sda_drv_q <= 1'b0;
                            end else begin
                                tx_q <= rd_data; sda_drv_q <= ~rd_data[7]; bit_q <= 4'h0;
                            end
                        end
                    end
                end
                default: st_q <= pmcd_pkg::ST_IDLE;
                endcase
            end
            if (clear_faults) cml_status <= pmcd_pkg::STATUS_RESET;
            if (!is_valid && st_q == pmcd_pkg::ST_CMD && scl_fall && bit_q == 4'h8)
                cml_status[pmcd_pkg::CML_INVALID] <= 1'b1;
        end
    end

    // stretch SCL low while the core is busy after a falling edge
    always_ff @(posedge mclk) begin
        if (reset) begin
            stretch_q <= 1'b0; str_cnt_q <= 8'h00;
        end else if (st_q != pmcd_pkg::ST_IDLE && scl_fall && core_busy) begin
            stretch_q <= 1'b1; str_cnt_q <= 8'(pmcd_pkg::STRETCH_CYC);
        end else if (stretch_q && !core_busy && str_cnt_q == 8'h00) begin
            stretch_q <= 1'b0;
        end else if (str_cnt_q != 8'h00) begin
            str_cnt_q <= str_cnt_q - 8'h01;
        end
    end

    // latched faults; new events win over a clear
    always_ff @(posedge mclk) begin
        if (reset) fault_q <= 8'h00;
        else fault_q <= (clear_faults ? 8'h00 : fault_q) | fault_in;
    end

    // no busy flag exists in any status view
    wire alert = (|fault_q) | cml_status[pmcd_pkg::CML_INVALID];
    assign fault_alert_out  = alert;
    assign fault_alert_oe_n = ~alert;
    assign sda_oe_n         = ~sda_drv_q;
    assign scl_oe_n         = ~stretch_q;

    sequence s_bad_code;
        st_q == pmcd_pkg::ST_CMD && scl_fall && bit_q == 4'h8 && !is_valid
        && !start_c && !stop_c;
    endsequence
    sequence s_flag_then_alert;
        cml_status[pmcd_pkg::CML_INVALID] && !cmd_strobe ##1 fault_alert_out;
    endsequence
    sequence s_host_nack;
        st_q == pmcd_pkg::ST_RDATA && scl_fall && bit_q == 4'h8 && sda_q
        && !start_c && !stop_c;
    endsequence
    property p_bad_cmd;
        @(posedge mclk) disable iff (reset) s_bad_code |=> s_flag_then_alert;
    endproperty
    bad_cmd_flag_a: assert property (p_bad_cmd) else $error("invalid command not flagged");
    no_prod_addr_a: assert property (@(posedge mclk) disable iff (reset)
        (st_q == pmcd_pkg::ST_ACK || st_q == pmcd_pkg::ST_RACK) && $past(st_q) == pmcd_pkg::ST_ADDR
        |-> addr_q != pmcd_pkg::ADDR_PROD) else $error("answered production address");
    alert_fault_a: assert property (@(posedge mclk) disable iff (reset)
        |fault_in |=> fault_alert_out && !fault_alert_oe_n) else $error("alert missed");
    clear_cml_a: assert property (@(posedge mclk) disable iff (reset)
        clear_faults |=> cml_status == 8'h00) else $error("clear faults failed");
    // straps reach addr_q three edges after they are sampled
    addr_calc_a: assert property (@(posedge mclk) disable iff (reset)
        !$past(reset) |-> addr_q == 7'($past(addr_strap_high, 3) * pmcd_pkg::STRAP_MULT
        + $past(addr_strap_low, 3))) else $error("address wrong");
    reject_8e_a: assert property (@(posedge mclk) disable iff (reset)
        cmd_strobe |-> cmd_code != 8'h8e && cmd_code != 8'h90 && cmd_code != 8'h00)
        else $error("unimplemented accepted");
    stretch_rel_a: assert property (@(posedge mclk) disable iff (reset)
        stretch_q && !core_busy && str_cnt_q == 8'h00 |=> !stretch_q)
        else $error("stretch not released");
    frame_stop_a: assert property (@(posedge mclk) disable iff (reset)
        stop_c |=> st_q == pmcd_pkg::ST_IDLE && !sda_drv_q) else $error("stop ignored");
    rd_nack_a: assert property (@(posedge mclk) disable iff (reset)
        s_host_nack |=> st_q == pmcd_pkg::ST_IDLE && !sda_drv_q) else $error("nack not released");
endmodule : pmcd_top
`default_nettype wire

// ==== pmcd_host_model.sv ====
/*
 * pmcd_host_model: behavioural bus host driving open-drain scl/sda.
 * Assumes the bench ands host and device pulls into scl_w/sda_w (pull-up).
 */
`timescale 1ns/1ns
`default_nettype none
module pmcd_host_model #(
    parameter int STORE_GAP_NS = 2000
) (
    input  wire logic scl_w,
    input  wire logic sda_w,
    output var logic  scl_h,
    output var logic  sda_h
);
    // store gap shortened from 20 ms to keep the run short
    initial begin
        scl_h = 1'b1;
        sda_h = 1'b1;
    end
    task automatic hi();
        scl_h = 1'b1;
        for (int i = 0; i < 4000 && scl_w !== 1'b1; i++) #4;
    endtask : hi
    // bit period 124 ns: 125 ns rounded to whole mclk cycles
    task automatic bit_io(input logic b, output logic r);
        #32 sda_h = b;
        #32 hi();
        #28 r = sda_w;
        #32 scl_h = 1'b0;
    endtask : bit_io
    task automatic send(input logic [7:0] tx, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(tx[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask : send
    task automatic recv(input logic last, output logic [7:0] rx);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, rx[i]);
        bit_io(last, r);
    endtask : recv
    task automatic start();
        #32 sda_h = 1'b1;
        #32 hi();
        #28 sda_h = 1'b0;
        #32 scl_h = 1'b0;
    endtask : start
    task automatic stop(input logic stored);
        #32 sda_h = 1'b0;
        #32 hi();
        #28 sda_h = 1'b1;
        #(stored ? STORE_GAP_NS : 600);
    endtask : stop
endmodule : pmcd_host_model
`default_nettype wire

// ==== pmbus_command_decoder_bench.sv ====
/*
 * pmbus_command_decoder_bench: self-checking bench for pmcd_top.
 * Assumes pmcd_host_model as bus host; straps static during transfers.
 */
`timescale 1ns/1ns
`default_nettype none
module pmbus_command_decoder_bench;
    logic mclk = 1'b0, reset = 1'b1, scl_h, sda_h, scl_oe_n, sda_oe_n, core_busy = 1'b0;
    logic [4:0] strap_lo = 5'h03;
    logic [2:0] strap_hi = 3'h1;
    logic [7:0] fault_in = 8'h00, rd_data = 8'h00, cmd_code, wr_data, cml_status, last_wr;
    logic cmd_strobe, wr_strobe, clear_faults, nvm_store, alert_oe_n, alert, ak;
    logic [6:0] addr = 7'h1c;
    int n_fail = 0, n_compared = 0, n_cmd = 0, n_clr = 0, n_nvm = 0, n_wr = 0, n_str = 0;
    wire logic scl_w = scl_h & scl_oe_n;
    wire logic sda_w = sda_h & sda_oe_n;
    localparam logic [7:0] CODES [16] = '{8'h03, 8'h78, 8'h7e, 8'h80, 8'h88, 8'h95, 8'hd0,
        8'he9, 8'hf2, 8'h00, 8'h10, 8'h35, 8'h8e, 8'h90, 8'h62, 8'h29};
    always #2 mclk = ~mclk;
    pmcd_host_model i_pmcd_host_model (.scl_w(scl_w), .sda_w(sda_w), .scl_h(scl_h),
        .sda_h(sda_h));
    pmcd_top i_pmcd_top (.mclk(mclk), .reset(reset), .scl_in(scl_w), .scl_oe_n(scl_oe_n),
        .sda_in(sda_w), .sda_oe_n(sda_oe_n), .addr_strap_low(strap_lo),
        .addr_strap_high(strap_hi), .fault_in(fault_in), .core_busy(core_busy),
        .fault_alert_oe_n(alert_oe_n), .fault_alert_out(alert), .cmd_code(cmd_code),
        .cmd_strobe(cmd_strobe), .wr_data(wr_data), .wr_strobe(wr_strobe), .rd_data(rd_data),
        .clear_faults(clear_faults), .nvm_store(nvm_store), .cml_status(cml_status));
    always @(posedge mclk) begin
        n_cmd <= n_cmd + (cmd_strobe === 1'b1);
        n_clr <= n_clr + (clear_faults === 1'b1);
        n_nvm <= n_nvm + (nvm_store === 1'b1);
        n_str <= n_str + (scl_oe_n === 1'b0);
        if (wr_strobe === 1'b1) begin
            n_wr <= n_wr + 1;
            last_wr <= wr_data;
        end
    end
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic wr_cmd(input logic [7:0] c, input logic stored, output logic ack);
        i_pmcd_host_model.start();
        i_pmcd_host_model.send({addr, 1'b0}, ack);
        i_pmcd_host_model.send(c, ack);
        i_pmcd_host_model.stop(stored);
    endtask : wr_cmd
    task automatic t_address();
        logic [2:0] hs [3] = '{3'h1, 3'h3, 3'h5};
        logic [4:0] ls [3] = '{5'h03, 5'h00, 5'h0a};
        int a;
        for (int i = 0; i < 3; i++) begin
            @(negedge mclk) strap_hi = hs[i];
            strap_lo = ls[i];
            a = 25 * hs[i] + ls[i];
            repeat (4) @(negedge mclk);
            i_pmcd_host_model.start();
            i_pmcd_host_model.send({a[6:0], 1'b0}, ak);
            i_pmcd_host_model.stop(1'b0);
            check("address ack", {7'h00, a < 128 && a != 75}, {7'h00, ak});
        end
        strap_hi = 3'h1;
        strap_lo = 5'h03;
        $display("t_address done");
    endtask : t_address
    task automatic t_commands();
        int c0, k0;
        logic good;
        for (int i = 0; i < 16; i++) begin
            good = i < 9;
            c0 = n_cmd;
            k0 = n_clr;
            wr_cmd(CODES[i], 1'b0, ak);
            check("cmd ack", {7'h00, good}, {7'h00, ak});
            check("cmd strobes", {7'h00, good}, 8'(n_cmd - c0));
            check("cmd code", CODES[i], cmd_code);
            check("invalid flag", {7'h00, !good}, {7'h00, cml_status[pmcd_pkg::CML_INVALID]});
            check("alert", {7'h00, !good}, {7'h00, alert});
            if (i == 0) check("clear pulses", 8'h01, 8'(n_clr - k0));
            if (!good) wr_cmd(pmcd_pkg::CMD_CLEAR, 1'b0, ak);
            if (!good) check("cml after clear", pmcd_pkg::STATUS_RESET, cml_status);
        end
        $display("t_commands done");
    endtask : t_commands
    task automatic t_write_read();
        logic [7:0] rx, rx2;
        int w0 = n_wr;
        i_pmcd_host_model.start();
        i_pmcd_host_model.send({addr, 1'b0}, ak);
        i_pmcd_host_model.send(pmcd_pkg::CMD_GEN_CFG, ak);
        i_pmcd_host_model.send(8'ha5, ak);
        i_pmcd_host_model.stop(1'b0);
        check("data ack", 8'h01, {7'h00, ak});
        check("written byte", 8'ha5, (n_wr - w0 == 1) ? last_wr : 8'hxx);
        rd_data = 8'h5a;
        i_pmcd_host_model.start();
        i_pmcd_host_model.send({addr, 1'b0}, ak);
        i_pmcd_host_model.send(pmcd_pkg::CMD_STAT_BYTE, ak);
        i_pmcd_host_model.start();
        i_pmcd_host_model.send({addr, 1'b1}, ak);
        // second byte has bit 6 low: a device that keeps driving after nack blocks the stop
        rd_data = 8'h96;
        i_pmcd_host_model.recv(1'b0, rx);
        i_pmcd_host_model.recv(1'b1, rx2);
        i_pmcd_host_model.stop(1'b0);
        check("read byte", 8'h5a, rx);
        check("second read byte", 8'h96, rx2);
        $display("t_write_read done");
    endtask : t_write_read
    task automatic t_store_stretch();
        int n0 = n_nvm, s0 = n_str;
        wr_cmd(pmcd_pkg::CMD_STORE_DEF, 1'b1, ak);
        wr_cmd(pmcd_pkg::CMD_STORE_USR, 1'b1, ak);
        check("store pulses", 8'h02, 8'(n_nvm - n0));
        // busy only for a window: a level held through the frame would stretch forever
        fork
            wr_cmd(pmcd_pkg::CMD_MISC_CFG, 1'b0, ak);
            begin
                repeat (100) @(negedge mclk);
                core_busy = 1'b1;
                repeat (200) @(negedge mclk);
                core_busy = 1'b0;
            end
        join
        check("ack while busy", 8'h01, {7'h00, ak});
        check("stretched", 8'h01, {7'h00, n_str - s0 >= pmcd_pkg::STRETCH_CYC});
        $display("t_store_stretch done");
    endtask : t_store_stretch
    task automatic t_alert();
        @(negedge mclk) fault_in = 8'h04;
        repeat (4) @(negedge mclk);
        check("alert on fault", 8'h01, {7'h00, alert});
        check("alert pull", 8'h00, {7'h00, alert_oe_n});
        fault_in = 8'h00;
        wr_cmd(pmcd_pkg::CMD_CLEAR, 1'b0, ak);
        check("alert cleared", 8'h00, {7'h00, alert});
        check("alert released", 8'h01, {7'h00, alert_oe_n});
        $display("t_alert done");
    endtask : t_alert
    task automatic print_verdict();
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (16) @(posedge mclk);
        @(negedge mclk) reset = 1'b0;
        repeat (4) @(negedge mclk);
        t_address();
        t_commands();
        t_write_read();
        t_store_stretch();
        t_alert();
        print_verdict();
    end
    initial begin
        // roughly twice the expected run
        #200000 n_fail++;
        print_verdict();
    end
endmodule : pmbus_command_decoder_bench
`default_nettype wire
